// [core/display_timing.sv]
// Local design decisions: the APB interface to the registers and the address map.
module display_timing
  import display_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // device pins in
  input wire logic main_timebase,
  input wire logic scan_format_select,
  input wire logic write_only_mode,
  input wire logic light_pen_strobe,
  // video
  output logic composite_sync,
  output logic blank_out,
  output logic vertical_blank,
  // display memory
  output logic [6:0] display_addr_mux,
  output logic [3:0] pixel_write_select,
  output logic all_chips_n,
  output logic erase_level,
  output logic memory_write_n,
  output logic memory_free_n,
  // interrupt, open drain
  input wire logic irq_in,
  output logic irq_out,
  output logic irq_oe_n,
  // light pen
  output logic force_white_n
);

  function automatic logic [3:0] one_hot(input logic [1:0] sel);
    one_hot = 4'h1 << sel;
  endfunction

  function automatic logic idx_is(input logic [ADDR_W-1:0] addr, input logic [3:0] idx);
    idx_is = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  scan_s scan;
  slot_e slot;
  logic tb_q;
  logic pen_prev_q;
  logic vb_prev_q;
  logic [6:0] control_one_q;
  logic [3:0] ctrl2_q;
  logic [11:0] x_q;
  logic [11:0] y_q;
  logic [6:0] pen_x_q;
  logic [7:0] pen_y_q;
  logic ready_q;
  logic pen_armed_q;
  logic dot_pend_q;
  logic free_pend_q;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic [6:0] row_q;
  logic [6:0] col_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic sync_q;
  logic blank_q;
  logic vb_q;
  logic [6:0] addr_q;
  logic [3:0] msl_q;
  logic all_n_q;
  logic erase_q;
  logic write_n_q;
  logic free_n_q;
  logic irq_oe_n_q;
  logic white_n_q;

  // falling edge of the master timebase steps the raster and the memory slot outputs
  wire tick = tb_q && !main_timebase;

  scan_gen u_scan (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick),
    .interlace(scan_format_select),
    .scan(scan)
  );

  mem_slot u_slot (
    .scan(scan),
    .write_only(write_only_mode),
    .fast_write(control_one_q[C1_FAST]),
    .dot_pending(dot_pend_q),
    .free_pending(free_pend_q),
    .slot(slot)
  );

  // bus decode: one wait state, then the access completes
  wire access = psel && penable && pready_q;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_status = idx_is(paddr, IDX_STATUS);
  wire hit_c1 = idx_is(paddr, IDX_CONTROL_ONE);
  wire hit_c2 = idx_is(paddr, IDX_CONTROL_TWO);
  wire hit_xh = idx_is(paddr, IDX_X_HI);
  wire hit_xl = idx_is(paddr, IDX_X_LO);
  wire hit_yh = idx_is(paddr, IDX_Y_HI);
  wire hit_yl = idx_is(paddr, IDX_Y_LO);
  wire hit_px = idx_is(paddr, IDX_PEN_X);
  wire hit_py = idx_is(paddr, IDX_PEN_Y);
  wire mapped = hit_status | hit_c1 | hit_c2 | hit_xh | hit_xl | hit_yh | hit_yl | hit_px | hit_py;
  wire [7:0] wbyte = pwdata[7:0];

  // commands are accepted only while ready; others are dropped
  wire cmd_wr = wr && hit_status && ready_q;
  wire cmd_arm = cmd_wr && (wbyte == CMD_PEN_ARM);
  wire cmd_free = cmd_wr && (wbyte == CMD_MEM_FREE);
  wire cmd_dot = cmd_wr && (wbyte == CMD_PLOT_DOT);
  wire cmd_other = cmd_wr && !cmd_arm && !cmd_free && !cmd_dot;
  wire dot_done = tick && (slot == SLOT_DOT);
  wire free_done = tick && (slot == SLOT_FREE);
  wire cmd_done = cmd_arm | cmd_other | dot_done | free_done;

  // light pen capture on a rising strobe while armed
  wire pen_hit = pen_armed_q && light_pen_strobe && !pen_prev_q;
  wire vb_rise = scan.vblank && !vb_prev_q;

  // sticky flags: a new event wins over the read clear
  wire [2:0] flag_evt = {cmd_done && control_one_q[C1_IE_CMD],
                         vb_rise && control_one_q[C1_IE_VB],
                         pen_hit && control_one_q[C1_IE_PEN]};
  wire status_read = rd && hit_status;
  wire summary = |flag_q;
  wire outside = (|x_q[11:9]) || (|y_q[11:9]);

  // a read clears only the flags its data showed, so an event landing mid-read is kept
  wire [2:0] flag_seen = prdata_q[ST_F_CMD:ST_F_PEN];

  always_comb begin
    flag_d = flag_q;
    if (status_read) begin
      flag_d = flag_q & ~flag_seen;
    end
    flag_d = flag_d | flag_evt;
  end

  wire [7:0] status_byte = {summary, flag_q, outside, ready_q, scan.vblank, !pen_armed_q};
  wire [7:0] rbyte = hit_status ? status_byte :
                     hit_c1 ? {1'b0, control_one_q} :
                     hit_c2 ? {4'h0, ctrl2_q} :
                     hit_xh ? {4'h0, x_q[11:8]} :
                     hit_xl ? x_q[7:0] :
                     hit_yh ? {4'h0, y_q[11:8]} :
                     hit_yl ? y_q[7:0] :
                     hit_px ? {1'b0, pen_x_q} :
                     hit_py ? pen_y_q : 8'h00;

  // address halves for the current slot
  wire dot_slot = (slot == SLOT_DOT);
  // dot writes and processor exchanges both address the x and y pointers
  wire xy_slot = dot_slot || (slot == SLOT_FREE);
  wire [6:0] row_d = xy_slot ? y_q[6:0] : scan.v[6:0];
  wire [6:0] col_d = xy_slot ? x_q[6:0] : scan.h;
  wire collective = (slot == SLOT_DISPLAY) || (slot == SLOT_REFRESH);

  // bus slave
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      prdata_q <= {24'h00_0000, rbyte};
      pslverr_q <= psel && penable && !pready_q && !mapped;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      control_one_q <= CONTROL_ONE_RST;
      ctrl2_q <= CONTROL_TWO_RST;
      x_q <= 12'h000;
      y_q <= 12'h000;
    end else if (wr) begin
      if (hit_c1) control_one_q <= wbyte[6:0];
      if (hit_c2) ctrl2_q <= wbyte[3:0];
      if (hit_xh) x_q[11:8] <= wbyte[3:0];
      if (hit_xl) x_q[7:0] <= wbyte;
      if (hit_yh) y_q[11:8] <= wbyte[3:0];
      if (hit_yl) y_q[7:0] <= wbyte;
    end
  end

  // command engine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b1;
      dot_pend_q <= 1'b0;
      free_pend_q <= 1'b0;
    end else begin
      if (cmd_dot) dot_pend_q <= 1'b1;
      else if (dot_done) dot_pend_q <= 1'b0;
      if (cmd_free) free_pend_q <= 1'b1;
      else if (free_done) free_pend_q <= 1'b0;
      if (cmd_dot || cmd_free) ready_q <= 1'b0;
      else if (dot_done || free_done) ready_q <= 1'b1;
    end
  end

  // light pen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pen_armed_q <= 1'b0;
      pen_prev_q <= 1'b0;
      pen_x_q <= 7'h00;
      pen_y_q <= 8'h00;
      white_n_q <= 1'b1;
    end else begin
      pen_prev_q <= light_pen_strobe;
      if (cmd_arm) pen_armed_q <= 1'b1;
      else if (pen_hit) pen_armed_q <= 1'b0;
      if (pen_hit) begin
        pen_x_q <= {scan.h[5:0], 1'b1};
        pen_y_q <= scan.v[7:0];
      end
      white_n_q <= !(pen_armed_q && !pen_hit);
    end
  end

  // status flags and interrupt drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 3'h0;
      // the raster starts inside vertical blanking, so no false rise after reset
      vb_prev_q <= 1'b1;
      irq_oe_n_q <= 1'b1;
    end else begin
      flag_q <= flag_d;
      vb_prev_q <= scan.vblank;
      irq_oe_n_q <= !(|flag_d);
    end
  end

  // timebase sampling and memory slot outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tb_q <= 1'b0;
      row_q <= 7'h00;
      col_q <= 7'h00;
      msl_q <= 4'h0;
      all_n_q <= 1'b1;
      write_n_q <= 1'b1;
      free_n_q <= 1'b1;
    end else begin
      tb_q <= main_timebase;
      if (tick) begin
        row_q <= row_d;
        col_q <= col_d;
        msl_q <= dot_slot ? one_hot(x_q[8:7]) : 4'h0;
        all_n_q <= write_only_mode || !collective;
        write_n_q <= !(dot_slot && control_one_q[C1_WRITE_EN]);
        free_n_q <= (slot != SLOT_FREE);
      end
    end
  end

  // pin-side video and address outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 7'h00;
      sync_q <= 1'b0;
      blank_q <= 1'b1;
      vb_q <= 1'b0;
      erase_q <= 1'b1;
    end else begin
      addr_q <= main_timebase ? col_q : row_q;
      sync_q <= scan.sync;
      blank_q <= scan.hblank || scan.vblank || control_one_q[C1_FAST];
      vb_q <= scan.vblank;
      erase_q <= !control_one_q[C1_PEN_SEL];
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign composite_sync = sync_q;
  assign blank_out = blank_q;
  assign vertical_blank = vb_q;
  assign display_addr_mux = addr_q;
  assign pixel_write_select = msl_q;
  assign all_chips_n = all_n_q;
  assign erase_level = erase_q;
  assign memory_write_n = write_n_q;
  assign memory_free_n = free_n_q;
  assign irq_out = 1'b0;
  assign irq_oe_n = irq_oe_n_q;
  assign force_white_n = white_n_q;

endmodule

// [shared/display_pkg.sv]
package display_pkg;

  // raster timing: horizontal counts in main_timebase periods, vertical counts in lines
  localparam int unsigned TB_NS = 571;
  localparam logic [6:0] LINE_LAST = 7'h6F;
  localparam logic [6:0] HSYNC_END = 7'h08;
  localparam logic [6:0] HDISP_START = 7'h14;
  localparam logic [6:0] HDISP_END = 7'h54;
  localparam logic [6:0] REFRESH_FIRST = 7'h0A;
  localparam logic [6:0] REFRESH_END = 7'h12;
  localparam logic [8:0] FIELD_LAST_LONG = 9'h138;
  localparam logic [8:0] FIELD_LAST_SHORT = 9'h137;
  localparam logic [8:0] VSYNC_END = 9'h003;
  localparam logic [8:0] VDISP_START = 9'h028;
  localparam logic [8:0] VDISP_END = 9'h128;

  // apb register indices, byte address is index times four
  localparam int unsigned ADDR_W = 6;
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_CONTROL_ONE = 4'h1;
  localparam logic [3:0] IDX_CONTROL_TWO = 4'h2;
  localparam logic [3:0] IDX_X_HI = 4'h8;
  localparam logic [3:0] IDX_X_LO = 4'h9;
  localparam logic [3:0] IDX_Y_HI = 4'hA;
  localparam logic [3:0] IDX_Y_LO = 4'hB;
  localparam logic [3:0] IDX_PEN_X = 4'hC;
  localparam logic [3:0] IDX_PEN_Y = 4'hD;

  // control_one fields
  localparam int unsigned C1_WRITE_EN = 0;
  localparam int unsigned C1_PEN_SEL = 1;
  localparam int unsigned C1_FAST = 2;
  localparam int unsigned C1_IE_PEN = 4;
  localparam int unsigned C1_IE_VB = 5;
  localparam int unsigned C1_IE_CMD = 6;
  localparam logic [6:0] CONTROL_ONE_RST = 7'h00;
  localparam logic [3:0] CONTROL_TWO_RST = 4'h0;

  // status fields
  localparam int unsigned ST_PEN_IDLE = 0;
  localparam int unsigned ST_VB = 1;
  localparam int unsigned ST_READY = 2;
  localparam int unsigned ST_OUTSIDE = 3;
  localparam int unsigned ST_F_PEN = 4;
  localparam int unsigned ST_F_VB = 5;
  localparam int unsigned ST_F_CMD = 6;
  localparam int unsigned ST_SUMMARY = 7;

  // command codes
  localparam logic [7:0] CMD_PEN_ARM = 8'h08;
  localparam logic [7:0] CMD_MEM_FREE = 8'h0F;
  localparam logic [7:0] CMD_PLOT_DOT = 8'h80;

  typedef enum logic [2:0] {
    SLOT_IDLE,
    SLOT_DISPLAY,
    SLOT_REFRESH,
    SLOT_DOT,
    SLOT_FREE
  } slot_e;

  typedef struct packed {
    logic [6:0] h;
    logic [8:0] v;
    logic hblank;
    logic vblank;
    logic sync;
  } scan_s;

endpackage

// [core/scan_gen.sv]
module scan_gen
  import display_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // timebase step and format
  input wire logic tick,
  input wire logic interlace,
  // raster position
  output scan_s scan
);

  logic [6:0] h_q;
  logic [8:0] v_q;
  logic field_q;
  wire line_end = (h_q == LINE_LAST);
  // interlaced fields alternate 313 and 312 lines, giving 625
  wire [8:0] field_last = (interlace && !field_q) ? FIELD_LAST_LONG : FIELD_LAST_SHORT;
  wire field_end = line_end && (v_q == field_last);
  wire hsync = (h_q < HSYNC_END);
  wire vsync = (v_q < VSYNC_END);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      h_q <= 7'h00;
      v_q <= 9'h000;
      field_q <= 1'b0;
    end else if (tick) begin
      h_q <= line_end ? 7'h00 : h_q + 7'h01;
      if (line_end) begin
        v_q <= field_end ? 9'h000 : v_q + 9'h001;
      end
      if (field_end) begin
        field_q <= interlace ? ~field_q : 1'b0;
      end
    end
  end

  assign scan.h = h_q;
  assign scan.v = v_q;
  assign scan.hblank = (h_q < HDISP_START) || (h_q >= HDISP_END);
  assign scan.vblank = (v_q < VDISP_START) || (v_q >= VDISP_END);
  // serrated composite sync; no register input reaches it, and of the modes only interlace does, through the field length
  assign scan.sync = vsync ? ~hsync : hsync;

endmodule

// [core/mem_slot.sv]
module mem_slot
  import display_pkg::*;
(
  // raster and modes
  input scan_s scan,
  input wire logic write_only,
  input wire logic fast_write,
  // pending requests
  input wire logic dot_pending,
  input wire logic free_pending,
  // chosen use of this memory slot
  output slot_e slot
);

  wire in_window = !scan.hblank && !scan.vblank;
  wire refresh_due = (scan.h >= REFRESH_FIRST) && (scan.h < REFRESH_END);
  wire display_slot = !write_only && in_window && !fast_write;
  wire refresh_slot = !write_only && refresh_due;

  assign slot = display_slot ? SLOT_DISPLAY :
                refresh_slot ? SLOT_REFRESH :
                dot_pending ? SLOT_DOT :
                free_pending ? SLOT_FREE : SLOT_IDLE;

endmodule

// [tb/display_timing_properties.sv]
module display_timing_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // inputs
  input wire logic write_only_mode,
  input wire logic light_pen_strobe,
  // pins
  input wire logic blank_out,
  input wire logic vertical_blank,
  input wire logic [3:0] pixel_write_select,
  input wire logic all_chips_n,
  input wire logic memory_write_n,
  input wire logic memory_free_n,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic force_white_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // strobe widths assume a timebase of six clocks
  a_apb_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("one wait state broken");
  a_ready_pulse: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready not a pulse");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_irq_summary: assert property (psel && penable && pready && !pwrite && paddr == 6'h00
    |-> prdata[7] == !$past(irq_oe_n))
    else $error("irq pin differs from summary");
  a_wo_collective: assert property (write_only_mode [*8] |-> all_chips_n)
    else $error("collective access in write-only");
  a_vb_blank: assert property (vertical_blank |-> blank_out)
    else $error("unblanked in vertical blank");
  a_dot_single: assert property (!memory_write_n |-> all_chips_n && $onehot(pixel_write_select))
    else $error("dot write not single");
  a_dot_width: assert property ($fell(memory_write_n) |-> !memory_write_n [*6] ##1 memory_write_n)
    else $error("write strobe width");
  a_free_width: assert property ($fell(memory_free_n) |-> !memory_free_n [*6] ##1 memory_free_n)
    else $error("free strobe width");
  a_free_idle: assert property (!memory_free_n |-> all_chips_n && memory_write_n)
    else $error("free outside idle slot");
  a_pen_release: assert property ($rose(light_pen_strobe) && !force_white_n |-> ##[1:8] force_white_n)
    else $error("pen not disarmed");
  a_irq_drain: assert property (!irq_oe_n |-> !irq_out)
    else $error("irq not open drain");
  c_dot: cover property (!memory_write_n);
  c_free: cover property (!memory_free_n);
  c_pen: cover property ($rose(force_white_n));
endmodule

bind display_timing display_timing_properties display_timing_properties_i (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .write_only_mode, .light_pen_strobe, .blank_out,
  .vertical_blank,
  .pixel_write_select, .all_chips_n, .memory_write_n, .memory_free_n, .irq_out, .irq_oe_n, .force_white_n);

// [tb/display_side_model.sv]
module display_side_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pen trigger
  input wire logic fire,
  // memory side
  input wire logic memory_write_n,
  input wire logic all_chips_n,
  // timebase and pen
  output logic main_timebase,
  output logic light_pen_strobe,
  output int dots
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] phase_q;
  logic write_q;
  // four clocks low, two high: both levels outlast their minimum width
  assign main_timebase = (phase_q > 3'h3);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
      write_q <= 1'b1;
      light_pen_strobe <= 1'b0;
      dots <= 0;
    end else begin
      phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
      write_q <= memory_write_n;
      light_pen_strobe <= fire;
      // a pixel is stored only when the strobe falls outside collective access
      if (write_q && !memory_write_n && all_chips_n) begin
        dots <= dots + 1;
      end
    end
  end
endmodule

// [tb/tb_top.sv]
module tb_top
  import display_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic scan_format_select = 1'b0, write_only_mode = 1'b0, fire = 1'b0, err;
  wire logic [31:0] prdata;
  wire logic [6:0] display_addr_mux;
  wire logic [3:0] pixel_write_select;
  wire logic pready, pslverr, main_timebase, light_pen_strobe, composite_sync, blank_out, vertical_blank;
  wire logic all_chips_n, erase_level, memory_write_n, memory_free_n, irq_out, irq_oe_n, force_white_n;
  wire logic irq_pin = irq_oe_n ? 1'b1 : irq_out;
  wire logic [4:0] watch = {vertical_blank, blank_out, force_white_n, memory_free_n, memory_write_n};
  int dots, lows, refresh, syncs;
  int error_cnt = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  display_timing display_timing_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .main_timebase, .scan_format_select, .write_only_mode, .light_pen_strobe,
    .composite_sync, .blank_out, .vertical_blank, .display_addr_mux, .pixel_write_select, .all_chips_n,
    .erase_level, .memory_write_n, .memory_free_n, .irq_in(irq_pin), .irq_out, .irq_oe_n, .force_white_n);
  display_side_model display_side_model_i (.clk, .rst_n, .fire, .memory_write_n, .all_chips_n,
    .main_timebase, .light_pen_strobe, .dots);

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      error_cnt++;
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(negedge clk);
  endtask

  task automatic wait_lvl(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (watch[b] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("pin level", v, watch[b]);
  endtask

  // while a strobe is low the address shows row or column of the x and y pointers
  task automatic addr_halves(input int b);
    logic lvl;
    repeat (5) begin
      lvl = main_timebase;
      @(negedge clk);
      if (watch[b] === 1'b0) chk("address half", lvl ? 32'h05 : 32'h10, display_addr_mux);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("reset pins", 32'h7F, {vertical_blank, pready, blank_out, all_chips_n, memory_write_n,
      memory_free_n, irq_oe_n, force_white_n, erase_level});
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 4'h3, 8'h00);
    chk("unmapped err", 32'h1, err);
    chk("vertical blank", 32'h1, vertical_blank);
    apb(1'b1, IDX_CONTROL_ONE, 8'h43);
    chk("erase pen", 32'h0, erase_level);
    apb(1'b1, IDX_CONTROL_ONE, 8'h41);
    chk("erase off code", 32'h1, erase_level);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, IDX_X_HI, {7'h00, k[1]});
      apb(1'b1, IDX_X_LO, {k[0], 7'h05});
      apb(1'b1, IDX_Y_LO, 8'h10);
      apb(1'b1, 4'h0, CMD_PLOT_DOT);
      wait_lvl(0, 1'b0, 3000);
      chk("pixel select", 32'h1 << k, pixel_write_select);
      addr_halves(0);
      wait_lvl(0, 1'b1, 20);
      chk("dots", k + 1, dots);
      chk("irq pin", 32'h0, irq_pin);
      apb(1'b0, IDX_STATUS, 8'h00);
      chk("status flags", 32'hC4, rd & 32'hC4);
      chk("irq released", 32'h1, irq_pin);
    end
    apb(1'b1, 4'h0, CMD_MEM_FREE);
    wait_lvl(1, 1'b0, 3000);
    addr_halves(1);
    apb(1'b1, 4'h0, CMD_PEN_ARM);
    wait_lvl(2, 1'b0, 20);
    @(posedge clk);
    fire <= 1'b1;
    repeat (3) @(posedge clk);
    fire <= 1'b0;
    wait_lvl(2, 1'b1, 20);
    apb(1'b0, IDX_PEN_X, 8'h00);
    chk("pen x lsb", 32'h1, rd & 32'h1);
    @(posedge clk);
    write_only_mode <= 1'b1;
    repeat (100) @(posedge clk);
    write_only_mode <= 1'b0;
    wait_lvl(4, 1'b0, 30000);
    wait_lvl(3, 1'b0, 800);
    apb(1'b1, IDX_CONTROL_ONE, 8'h45);
    repeat (20) @(negedge clk);
    lows = 0;
    refresh = 0;
    syncs = 0;
    repeat (700) begin
      @(negedge clk);
      if (blank_out !== 1'b1) lows++;
      if (all_chips_n === 1'b0) refresh++;
      if (composite_sync === 1'b1) syncs++;
    end
    chk("sync in fast mode", 32'h1, syncs >= 48 && syncs <= 96);
    chk("fast blank", 32'h0, lows);
    chk("refresh only", 32'h1, refresh > 0 && refresh <= 96);
    end_of_test();
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
